// [verilog/pmc_defs.vh]
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH

// ****************************************
// Port numbers of the command registers
// ****************************************
`define PMC_PORT_STATUS 5'h0e
`define PMC_PORT_STOP 5'h10
`define PMC_PORT_IDLE 5'h13
`define PMC_PORT_MODE 5'h16
`define PMC_PORT_TBASE 5'h19

// ****************************************
// Field positions
// ****************************************
`define PMC_MODE_SLOW_BIT 3
`define PMC_ST_CPU_BIT 0
`define PMC_ST_LFS_BIT 1
`define PMC_ST_WAKE_BIT 2
`define PMC_ENTRY_BIT 3
`define PMC_SEL_LSB 0
`define PMC_TB_EN_BIT 2

// ****************************************
// Reset values
// ****************************************
`define PMC_RST_NIBBLE 4'h0

// ****************************************
// Timing: clock in Hz, wake times in ms or us, stages as powers of two of low-frequency periods
// ****************************************
`define PMC_LF_HZ 32768
`define PMC_WAKE_1S_MS 1000
`define PMC_WAKE_HALF_MS 500
`define PMC_WAKE_FAST_US 15625
`define PMC_WAKE_1S_STAGE 5'd15
`define PMC_WAKE_HALF_STAGE 5'd14
`define PMC_WAKE_FAST_STAGE 5'd9
`define PMC_WARM_00_STAGE 5'd14
`define PMC_WARM_01_STAGE 5'd10
`define PMC_WARM_10_STAGE 5'd12
`define PMC_TB_STAGES 22

`endif

// [verilog/pmc_sync.v]
`default_nettype none

// ****************************************
// Two-stage synchroniser for pin inputs
// ****************************************
module pmc_sync #(
    parameter WIDTH = 1
) (
    input wire mclk_i,
    input wire nrst_i,
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta;

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta <= {WIDTH{1'b0}};
            sync_o <= {WIDTH{1'b0}};
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule // pmc_sync

`default_nettype wire

// [verilog/pmc_tbase.v]
`include "pmc_defs.vh"
`default_nettype none

// ****************************************
// Time base: synchronous count of low-frequency clock edges
// ****************************************
module pmc_tbase (
    input wire mclk_i,
    input wire nrst_i,
    input wire lf_tick_i,
    output reg [`PMC_TB_STAGES-1:0] count_o
);
    // Advances only on low-frequency edges, so it freezes in stop
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_o <= {`PMC_TB_STAGES{1'b0}};
        end else if (lf_tick_i) begin
            count_o <= count_o + {{(`PMC_TB_STAGES-1){1'b0}}, 1'b1};
        end
    end
endmodule // pmc_tbase

`default_nettype wire

// [verilog/pmc_top.v]
`include "pmc_defs.vh"
`default_nettype none

module pmc_top (
    input wire mclk_i,
    input wire nrst_i,
    input wire [4:0] port_addr_i,
    input wire port_wr_i,
    input wire [3:0] port_wdata_i,
    output reg [3:0] port_rdata_o,
    input wire low_freq_clock_i,
    input wire low_osc_ready_i,
    input wire [7:0] wake_pins_i,
    output reg high_osc_en_o,
    output reg low_osc_en_o,
    output reg cpu_clk_low_o,
    output reg cpu_halt_o,
    output reg lcd_en_o,
    output reg speech_en_o,
    output reg sound_en_o,
    output reg periodic_tick_interrupt_o
);
    // ****************************************
    // States
    // ****************************************
    localparam [2:0] ST_DUAL = 3'd0;
    localparam [2:0] ST_SLOW = 3'd1;
    localparam [2:0] ST_IDLE = 3'd2;
    localparam [2:0] ST_STOP = 3'd3;
    localparam [2:0] ST_WARM = 3'd4;

    // ****************************************
    // Functions
    // ****************************************
    // True when the low n bits of c are all ones, i.e. the next
    // low-frequency edge completes a period of 2^n
    function tap_roll;
        input [`PMC_TB_STAGES-1:0] c;
        input [4:0] n;
        reg [`PMC_TB_STAGES-1:0] m;
        begin
            m = ({{(`PMC_TB_STAGES-1){1'b0}}, 1'b1} << n)
                - {{(`PMC_TB_STAGES-1){1'b0}}, 1'b1};
            tap_roll = ((c & m) == m);
        end
    endfunction

    // Time base code to divisor stage; bit 5 flags a usable code
    function [5:0] tb_stage;
        input [3:0] code;
        input slow;
        begin
            tb_stage = 6'h00;
            if (code[`PMC_TB_EN_BIT]) begin
                case ({code[3], code[1:0]})
                    3'b000: tb_stage = {~slow, 5'd3};
                    3'b001: tb_stage = {~slow, 5'd4};
                    3'b010: tb_stage = {~slow, 5'd5};
                    3'b011: tb_stage = {1'b1, 5'd14};
                    3'b100: tb_stage = {~slow, 5'd1};
                    3'b101: tb_stage = {1'b1, 5'd6};
                    3'b110: tb_stage = {1'b1, 5'd8};
                    default: tb_stage = {1'b1, 5'd10};
                endcase
            end
        end
    endfunction

    // ****************************************
    // Declarations
    // ****************************************
    reg [2:0] state;
    reg [2:0] next_state;
    reg [3:0] mode_sel;
    reg [3:0] idle_ctl;
    reg [3:0] stop_ctl;
    reg [3:0] tbase_sel;
    reg timer_wake_flag;
    reg lf_prev;
    reg [`PMC_TB_STAGES-1:0] warm_cnt;
    wire lf_sync;
    wire low_osc_stable_flag;
    wire [7:0] pins_sync;
    wire [`PMC_TB_STAGES-1:0] tb_count;
    wire lf_tick;
    wire pin_wake;
    wire cpu_mode_flag;
    wire [1:0] idle_release_select;
    wire [1:0] warmup_select;
    wire mode_select_field;
    wire [5:0] tb_sel;
    reg timer_wake;
    reg warm_done;
    reg [4:0] warm_stage;
    wire wr_mode;
    wire wr_idle;
    wire wr_stop;
    wire wr_status;
    wire wr_tbase;
    wire idle_req;
    wire stop_req;

    // ****************************************
    // Pin synchronisers and time base
    // ****************************************
    pmc_sync #(
        .WIDTH(10)
    ) u_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .async_i({wake_pins_i, low_osc_ready_i, low_freq_clock_i}),
        .sync_o({pins_sync, low_osc_stable_flag, lf_sync})
    );

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lf_prev <= 1'b0;
        end else begin
            lf_prev <= lf_sync;
        end
    end

    assign lf_tick = lf_sync & ~lf_prev;

    pmc_tbase u_tbase (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .lf_tick_i(lf_tick),
        .count_o(tb_count)
    );

    // ****************************************
    // Register decode
    // ****************************************
    assign wr_mode = port_wr_i && (port_addr_i == `PMC_PORT_MODE);
    assign wr_idle = port_wr_i && (port_addr_i == `PMC_PORT_IDLE);
    assign wr_stop = port_wr_i && (port_addr_i == `PMC_PORT_STOP);
    assign wr_status = port_wr_i && (port_addr_i == `PMC_PORT_STATUS);
    assign wr_tbase = port_wr_i && (port_addr_i == `PMC_PORT_TBASE);

    assign mode_select_field = mode_sel[`PMC_MODE_SLOW_BIT];
    assign idle_release_select = idle_ctl[`PMC_SEL_LSB+1:`PMC_SEL_LSB];
    assign warmup_select = stop_ctl[`PMC_SEL_LSB+1:`PMC_SEL_LSB];
    assign cpu_mode_flag = (state != ST_DUAL);

    // Warm-up select 11 has no function, so it also refuses entry
    assign stop_req = wr_stop && port_wdata_i[`PMC_ENTRY_BIT]
                      && (port_wdata_i[1:0] != 2'b11);
    assign idle_req = wr_idle && port_wdata_i[`PMC_ENTRY_BIT]
                      && (state == ST_SLOW);

    // ****************************************
    // Wake sources
    // ****************************************
    assign pin_wake = |pins_sync;

    always @* begin
        timer_wake = 1'b0;
        if (lf_tick) begin
            case (idle_release_select)
                2'b01: timer_wake = tap_roll(tb_count, `PMC_WAKE_1S_STAGE);
                2'b10: timer_wake = tap_roll(tb_count, `PMC_WAKE_HALF_STAGE);
                2'b11: timer_wake = tap_roll(tb_count, `PMC_WAKE_FAST_STAGE);
                default: timer_wake = 1'b0;
            endcase
        end
    end

    always @* begin
        case (warmup_select)
            2'b01: warm_stage = `PMC_WARM_01_STAGE;
            2'b10: warm_stage = `PMC_WARM_10_STAGE;
            default: warm_stage = `PMC_WARM_00_STAGE;
        endcase
        warm_done = lf_tick && tap_roll(warm_cnt, warm_stage);
    end

    // ****************************************
    // Mode state machine
    // ****************************************
    always @* begin
        next_state = state;
        case (state)
            ST_DUAL: begin
                if (stop_req) begin
                    next_state = ST_STOP;
                end else if (wr_mode && port_wdata_i[`PMC_MODE_SLOW_BIT]) begin
                    next_state = ST_SLOW;
                end
            end
            ST_SLOW: begin
                if (stop_req) begin
                    next_state = ST_STOP;
                end else if (idle_req) begin
                    next_state = ST_IDLE;
                end else if (wr_mode && !port_wdata_i[`PMC_MODE_SLOW_BIT]) begin
                    next_state = ST_DUAL;
                end
            end
            ST_IDLE: begin
                if (timer_wake || pin_wake) begin
                    next_state = ST_SLOW;
                end
            end
            ST_STOP: begin
                if (pin_wake) begin
                    next_state = ST_WARM;
                end
            end
            ST_WARM: begin
                if (warm_done) begin
                    next_state = mode_select_field ? ST_SLOW : ST_DUAL;
                end
            end
            default: begin
                next_state = ST_DUAL;
            end
        endcase
    end

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= ST_DUAL;
        end else begin
            state <= next_state;
        end
    end

    // Warm-up count restarts on every stop wake
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            warm_cnt <= {`PMC_TB_STAGES{1'b0}};
        end else if (state != ST_WARM) begin
            warm_cnt <= {`PMC_TB_STAGES{1'b0}};
        end else if (lf_tick) begin
            warm_cnt <= warm_cnt + {{(`PMC_TB_STAGES-1){1'b0}}, 1'b1};
        end
    end

    // ****************************************
    // Command registers
    // ****************************************
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_sel <= `PMC_RST_NIBBLE;
            idle_ctl <= `PMC_RST_NIBBLE;
            stop_ctl <= `PMC_RST_NIBBLE;
            tbase_sel <= `PMC_RST_NIBBLE;
        end else begin
            if (wr_mode && (state == ST_DUAL || state == ST_SLOW)) begin
                mode_sel <= port_wdata_i;
            end
            if (wr_tbase) begin
                tbase_sel <= port_wdata_i;
            end
            if (wr_idle) begin
                idle_ctl <= {idle_req, port_wdata_i[2:0]};
            end else if (state == ST_IDLE && next_state != ST_IDLE) begin
                idle_ctl[`PMC_ENTRY_BIT] <= 1'b0;
            end
            if (wr_stop) begin
                stop_ctl <= {stop_req, port_wdata_i[2:0]};
            end else if (state == ST_WARM && next_state != ST_WARM) begin
                stop_ctl[`PMC_ENTRY_BIT] <= 1'b0;
            end
        end
    end

    // Set wins over the clearing write in the same cycle
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timer_wake_flag <= 1'b0;
        end else if (state == ST_IDLE && timer_wake) begin
            timer_wake_flag <= 1'b1;
        end else if (wr_status) begin
            timer_wake_flag <= 1'b0;
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_rdata_o <= 4'h0;
        end else if (port_addr_i == `PMC_PORT_STATUS) begin
            port_rdata_o <= {1'b0, timer_wake_flag, low_osc_stable_flag, cpu_mode_flag};
        end else if (port_addr_i == `PMC_PORT_MODE) begin
            port_rdata_o <= mode_sel;
        end else if (port_addr_i == `PMC_PORT_IDLE) begin
            port_rdata_o <= idle_ctl;
        end else if (port_addr_i == `PMC_PORT_STOP) begin
            port_rdata_o <= stop_ctl;
        end else if (port_addr_i == `PMC_PORT_TBASE) begin
            port_rdata_o <= tbase_sel;
        end else begin
            port_rdata_o <= 4'h0;
        end
    end

    // ****************************************
    // Time base interrupt
    // ****************************************
    // Reserved codes in slow mode simply produce no interrupt
    assign tb_sel = tb_stage(tbase_sel, cpu_mode_flag);

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            periodic_tick_interrupt_o <= 1'b0;
        end else begin
            periodic_tick_interrupt_o <= lf_tick && tb_sel[5]
                                         && tap_roll(tb_count, tb_sel[4:0]);
        end
    end

    // ****************************************
    // Clock and function enables
    // ****************************************
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            high_osc_en_o <= 1'b1;
            low_osc_en_o <= 1'b1;
            cpu_clk_low_o <= 1'b0;
            cpu_halt_o <= 1'b0;
            lcd_en_o <= 1'b1;
            speech_en_o <= 1'b1;
            sound_en_o <= 1'b1;
        end else begin
            case (next_state)
                ST_DUAL: begin
                    high_osc_en_o <= 1'b1;
                    low_osc_en_o <= 1'b1;
                    cpu_clk_low_o <= 1'b0;
                    cpu_halt_o <= 1'b0;
                    lcd_en_o <= 1'b1;
                    speech_en_o <= 1'b1;
                    sound_en_o <= 1'b1;
                end
                ST_SLOW: begin
                    high_osc_en_o <= 1'b0;
                    low_osc_en_o <= 1'b1;
                    cpu_clk_low_o <= 1'b1;
                    cpu_halt_o <= 1'b0;
                    lcd_en_o <= 1'b1;
                    speech_en_o <= 1'b0;
                    sound_en_o <= 1'b0;
                end
                ST_IDLE: begin
                    high_osc_en_o <= 1'b0;
                    low_osc_en_o <= 1'b1;
                    cpu_clk_low_o <= 1'b1;
                    cpu_halt_o <= 1'b1;
                    lcd_en_o <= 1'b1;
                    speech_en_o <= 1'b0;
                    sound_en_o <= 1'b0;
                end
                ST_STOP: begin
                    high_osc_en_o <= 1'b0;
                    low_osc_en_o <= 1'b0;
                    cpu_clk_low_o <= cpu_mode_flag;
                    cpu_halt_o <= 1'b1;
                    lcd_en_o <= 1'b0;
                    speech_en_o <= 1'b0;
                    sound_en_o <= 1'b0;
                end
                default: begin
                    // Warm-up: low oscillator restarts, high one only for a dual return, CPU still held
                    high_osc_en_o <= ~mode_select_field;
                    low_osc_en_o <= 1'b1;
                    cpu_clk_low_o <= mode_select_field;
                    cpu_halt_o <= 1'b1;
                    lcd_en_o <= 1'b0;
                    speech_en_o <= 1'b0;
                    sound_en_o <= 1'b0;
                end
            endcase
        end
    end
endmodule // pmc_top

`default_nettype wire

// [test/pmc_top_assertions.sv]
`include "pmc_defs.vh"
`default_nettype none

// ****************************************
// Port-level checks of the mode controller
// ****************************************
module pmc_top_assertions (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [4:0] port_addr_i,
    input wire logic port_wr_i,
    input wire logic [3:0] port_wdata_i,
    input wire logic [3:0] port_rdata_o,
    input wire logic [7:0] wake_pins_i,
    input wire logic high_osc_en_o,
    input wire logic low_osc_en_o,
    input wire logic cpu_clk_low_o,
    input wire logic cpu_halt_o,
    input wire logic lcd_en_o,
    input wire logic speech_en_o,
    input wire logic sound_en_o,
    input wire logic periodic_tick_interrupt_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    // Writes only count while the CPU runs
    wire logic wr_mode = port_wr_i && port_addr_i == `PMC_PORT_MODE && !cpu_halt_o;
    wire logic wr_stop = port_wr_i && port_addr_i == `PMC_PORT_STOP && !cpu_halt_o && port_wdata_i[3];
    wire logic wr_idle = port_wr_i && port_addr_i == `PMC_PORT_IDLE && !cpu_halt_o && port_wdata_i[3];
    wire logic wr_stat = port_wr_i && port_addr_i == `PMC_PORT_STATUS && !cpu_halt_o;

    a_reset_dual_mode:
        assert property ($rose(nrst_i) |-> high_osc_en_o && low_osc_en_o && !cpu_clk_low_o && !cpu_halt_o
            && lcd_en_o && speech_en_o && sound_en_o) else $error("outputs not in dual mode after reset");
    a_slow_entry_outs:
        assert property (wr_mode && port_wdata_i[3] |=> cpu_clk_low_o && !high_osc_en_o && low_osc_en_o
            && lcd_en_o && !speech_en_o && !sound_en_o) else $error("slow mode outputs wrong");
    a_dual_return_outs:
        assert property (wr_mode && !port_wdata_i[3] |=> !cpu_clk_low_o && high_osc_en_o && lcd_en_o
            && speech_en_o && sound_en_o) else $error("dual mode outputs wrong");
    a_stop_entry_outs:
        assert property (wr_stop && port_wdata_i[1:0] != 2'h3 |=> cpu_halt_o && !high_osc_en_o
            && !low_osc_en_o && !lcd_en_o && !sound_en_o) else $error("stop mode outputs wrong");
    a_stop_sel_refused:
        assert property (wr_stop && port_wdata_i[1:0] == 2'h3 |=> !cpu_halt_o)
        else $error("stop entered with unused warm-up code");
    a_idle_entry_outs:
        assert property (wr_idle && cpu_clk_low_o |=> cpu_halt_o && low_osc_en_o && lcd_en_o
            && !high_osc_en_o && !sound_en_o) else $error("idle mode outputs wrong");
    a_idle_dual_refused:
        assert property (wr_idle && !cpu_clk_low_o |=> !cpu_halt_o [*2])
        else $error("idle entered from dual mode");
    a_stop_needs_pin:
        assert property (cpu_halt_o && !low_osc_en_o && wake_pins_i == 8'h00 && $past(wake_pins_i) == 8'h00
            && $past(wake_pins_i, 2) == 8'h00 && $past(wake_pins_i, 3) == 8'h00 |=> cpu_halt_o && !low_osc_en_o)
        else $error("stop left without a wake pin");
    a_tick_one_cycle:
        assert property (periodic_tick_interrupt_o |=> !periodic_tick_interrupt_o)
        else $error("tick pulse longer than one cycle");
    a_status_wr_clear:
        assert property (wr_stat ##1 port_addr_i == `PMC_PORT_STATUS |=> port_rdata_o[2] == 1'b0)
        else $error("wake flag not cleared by status write");
    a_cpu_flag_read:
        assert property (port_addr_i == `PMC_PORT_STATUS && !cpu_halt_o && $stable(cpu_clk_low_o)
            |=> port_rdata_o[0] == $past(cpu_clk_low_o)) else $error("cpu mode flag wrong");
endmodule // pmc_top_assertions

bind pmc_top pmc_top_assertions pmc_top_assertions_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .port_addr_i(port_addr_i), .port_wr_i(port_wr_i), .port_wdata_i(port_wdata_i),
    .port_rdata_o(port_rdata_o), .wake_pins_i(wake_pins_i), .high_osc_en_o(high_osc_en_o),
    .low_osc_en_o(low_osc_en_o), .cpu_clk_low_o(cpu_clk_low_o), .cpu_halt_o(cpu_halt_o),
    .lcd_en_o(lcd_en_o), .speech_en_o(speech_en_o), .sound_en_o(sound_en_o),
    .periodic_tick_interrupt_o(periodic_tick_interrupt_o));

`default_nettype wire

// [test/pmc_top_test.sv]
`include "pmc_defs.vh"
`default_nettype none

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end

// ****************************************
// Self-checking bench of the mode controller
// ****************************************
module pmc_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    // Output order: high, low, cpu_low, halt, lcd, speech, sound
    localparam logic [6:0] DUAL = 7'h67;
    localparam logic [6:0] SLOW = 7'h34;
    localparam logic [6:0] IDLE = 7'h2c;
    localparam logic [6:0] STOP = 7'h08;
    localparam logic [6:0] ALL = 7'h7f;
    localparam logic [6:0] LP = 7'h6d;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [4:0] port_addr_i = 5'h00;
    logic port_wr_i = 1'b0;
    logic [3:0] port_wdata_i = 4'h0;
    logic low_freq_clock_i = 1'b0;
    logic low_osc_ready_i = 1'b0;
    logic [7:0] wake_pins_i = 8'h00;
    wire logic [3:0] port_rdata_o;
    wire logic high_osc_en_o, low_osc_en_o, cpu_clk_low_o, cpu_halt_o;
    wire logic lcd_en_o, speech_en_o, sound_en_o, periodic_tick_interrupt_o;
    wire logic [6:0] outs = {high_osc_en_o, low_osc_en_o, cpu_clk_low_o, cpu_halt_o, lcd_en_o, speech_en_o,
        sound_en_o};
    logic [3:0] tb_code [7] = '{4'h4, 4'h5, 4'h6, 4'hc, 4'hd, 4'he, 4'hf};
    int tb_div [7] = '{8, 16, 32, 2, 64, 256, 1024};
    logic [4:0] regs [5] = '{5'h00, `PMC_PORT_STOP, `PMC_PORT_IDLE, `PMC_PORT_MODE, `PMC_PORT_TBASE};
    logic [3:0] rv;
    int error_cnt = 0;
    int n_compared = 0;
    int lf_edges = 0;
    int ticks = 0;
    int k;

    pmc_top pmc_top_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .port_addr_i(port_addr_i), .port_wr_i(port_wr_i),
        .port_wdata_i(port_wdata_i), .port_rdata_o(port_rdata_o), .low_freq_clock_i(low_freq_clock_i),
        .low_osc_ready_i(low_osc_ready_i), .wake_pins_i(wake_pins_i), .high_osc_en_o(high_osc_en_o),
        .low_osc_en_o(low_osc_en_o), .cpu_clk_low_o(cpu_clk_low_o), .cpu_halt_o(cpu_halt_o),
        .lcd_en_o(lcd_en_o), .speech_en_o(speech_en_o), .sound_en_o(sound_en_o),
        .periodic_tick_interrupt_o(periodic_tick_interrupt_o));

    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    // Fast low clock keeps the long counts short; offset keeps it off the system edge
    // Halts while the oscillator is switched off, so stop really freezes the time base
    initial begin
        #7;
        forever #15 if (low_osc_en_o !== 1'b0) low_freq_clock_i = ~low_freq_clock_i;
    end
    always @(posedge low_freq_clock_i) lf_edges++;
    always @(posedge mclk_i) if (periodic_tick_interrupt_o === 1'b1) ticks++;

    task automatic wr(input logic [4:0] a, input logic [3:0] d);
        @(posedge mclk_i);
        #1;
        port_addr_i = a;
        port_wdata_i = d;
        port_wr_i = 1'b1;
        @(posedge mclk_i);
        #1;
        port_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [3:0] d);
        @(posedge mclk_i);
        #1;
        port_addr_i = a;
        @(posedge mclk_i);
        #1;
        d = port_rdata_o;
    endtask

    task automatic chk_mode(input logic [6:0] e, input logic [6:0] m);
        `CHK(outs & m, e & m)
    endtask

    task automatic near(input int d, input int n);
        `CHK((d >= n - 2) && (d <= n + 2), 1'b1)
    endtask

    task automatic wait_halt(input logic lvl, input int lim);
        for (int i = 0; i < lim && cpu_halt_o !== lvl; i++) begin
            @(posedge mclk_i);
            #1;
        end
        `CHK(cpu_halt_o, lvl)
    endtask

    task automatic wait_tick(input int n);
        for (int i = 0; i < 8 * n + 100 && periodic_tick_interrupt_o !== 1'b1; i++) begin
            @(posedge mclk_i);
            #1;
        end
    endtask

    task automatic tb_period(input logic [3:0] code, input int n);
        int e0;
        wr(`PMC_PORT_TBASE, code);
        wait_tick(n);
        e0 = lf_edges;
        @(posedge mclk_i);
        #1;
        wait_tick(n);
        near(lf_edges - e0, n);
    endtask

    task automatic stop_wake(input logic [1:0] sel, input int n, input logic [6:0] back);
        int e0;
        wr(`PMC_PORT_STOP, {2'h2, sel});
        chk_mode(STOP, LP);
        repeat (20) @(posedge mclk_i);
        #1;
        `CHK(cpu_halt_o, 1'b1)
        wake_pins_i = 8'h80;
        e0 = lf_edges;
        wait_halt(1'b0, 4 * n + 100);
        wake_pins_i = 8'h00;
        near(lf_edges - e0, n);
        chk_mode(back, ALL);
        rd(`PMC_PORT_STOP, rv);
        `CHK(rv[3], 1'b0)
        repeat (4) @(posedge mclk_i);
    endtask

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Worst case of all tests is about 0.9 ms of simulated time
    initial begin
        #1000000;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        repeat (4) @(posedge mclk_i);
        #1;
        nrst_i = 1'b1;
        chk_mode(DUAL, ALL);
        foreach (regs[j]) begin
            rd(regs[j], rv);
            `CHK(rv, 4'h0)
        end
        rd(`PMC_PORT_STATUS, rv);
        `CHK(rv[2:0], 3'h0)
        low_osc_ready_i = 1'b1;
        wr(`PMC_PORT_STATUS, 4'hf);
        rd(`PMC_PORT_STATUS, rv);
        `CHK(rv[2:0], 3'h2)
        wr(`PMC_PORT_IDLE, 4'h8);
        chk_mode(DUAL, ALL);
        $display("reset and status test done");
        for (k = 0; k < 7; k++) tb_period(tb_code[k], tb_div[k]);
        wr(`PMC_PORT_TBASE, 4'h3);
        k = ticks;
        repeat (600) @(posedge mclk_i);
        #1;
        `CHK(ticks - k, 0)
        $display("dual time base test done");
        wr(`PMC_PORT_MODE, 4'h8);
        chk_mode(SLOW, ALL);
        rd(`PMC_PORT_MODE, rv);
        `CHK(rv, 4'h8)
        rd(`PMC_PORT_STATUS, rv);
        `CHK(rv[1:0], 2'h3)
        for (k = 4; k < 7; k++) tb_period(tb_code[k], tb_div[k]);
        wr(`PMC_PORT_TBASE, 4'h4);
        k = ticks;
        repeat (600) @(posedge mclk_i);
        #1;
        `CHK(ticks - k, 0)
        wr(`PMC_PORT_TBASE, 4'h0);
        $display("slow mode test done");
        for (k = 0; k < 8; k++) begin
            wr(`PMC_PORT_IDLE, 4'h8);
            chk_mode(IDLE, LP);
            rd(`PMC_PORT_IDLE, rv);
            `CHK(rv[3], 1'b1)
            wake_pins_i = 8'(1 << k);
            wait_halt(1'b0, 20);
            wake_pins_i = 8'h00;
            chk_mode(SLOW, ALL);
            rd(`PMC_PORT_STATUS, rv);
            `CHK(rv[2], 1'b0)
            repeat (4) @(posedge mclk_i);
        end
        wr(`PMC_PORT_IDLE, 4'h8);
        repeat (2000) @(posedge mclk_i);
        #1;
        `CHK(cpu_halt_o, 1'b1)
        wake_pins_i = 8'h10;
        wait_halt(1'b0, 20);
        wake_pins_i = 8'h00;
        repeat (4) @(posedge mclk_i);
        wr(`PMC_PORT_IDLE, 4'hb);
        wait_halt(1'b0, 2500);
        chk_mode(SLOW, ALL);
        rd(`PMC_PORT_IDLE, rv);
        `CHK(rv[3], 1'b0)
        rd(`PMC_PORT_STATUS, rv);
        `CHK(rv[2], 1'b1)
        wr(`PMC_PORT_STATUS, 4'h0);
        rd(`PMC_PORT_STATUS, rv);
        `CHK(rv[2], 1'b0)
        $display("idle mode test done");
        stop_wake(2'h1, 1024, SLOW);
        wr(`PMC_PORT_MODE, 4'h0);
        chk_mode(DUAL, ALL);
        wr(`PMC_PORT_STOP, 4'hb);
        chk_mode(DUAL, ALL);
        stop_wake(2'h2, 4096, DUAL);
        stop_wake(2'h0, 16384, DUAL);
        $display("stop mode test done");
        finish_test();
    end
endmodule // pmc_top_test

`default_nettype wire
